/* core/cas_core.v */
// Summary of operation
// R1: An operand naming the indirect location acts on the pointer-addressed register.
// R2: Bank selection uses pointer upper bits; banks 0-7 are 010h to 0F0h.
// R3: Indirect access reaches all 256 data locations via the full pointer.
// R4: Bank instruction writes only pointer bank bits, in one cycle.
// R5: Any bit of any data location can be set, cleared or tested.
// R6: Decrement/increment skip update the register and skip when result is zero.
// R7: An eight-level hardware return-address stack is provided.
// R8: Jump loads nine target bits and two page-select bits into the PC.
// R9: Page instruction sets page-select bits to 0..3 in one cycle.
// R10: Call pushes the incremented program counter first.
// R11: Call loads eight target bits, clears bit 8, page bits on top.
// R12: Plain return pops the stack into PC, working register unchanged.
// R13: Paged return is a plain return that also changes page-select bits.
// R14: Return-and-add returns and adds the working register to the counter.
// R15: Return-with-literal returns and loads the literal into the working register.
// R16: Push shifts levels deeper, level 1 takes PC, level 8 lost.
// R17: Pop copies level 1 to PC, shifts up, level 8 kept.
// R18: Each stack entry is eleven bits, the full PC width.
// R19: Page-select bits sit at status bits 6:5.
// R20: Page or bank instructions after a taken skip are all skipped too.
// R21: Paged return takes page bits from the popped address top bits.
`include "cas_map.vh"
module cas_core #(
  parameter PC_W  = 11,
  parameter DEPTH = 8
) (
  input  wire            clk,
  input  wire            reset_n,
  input  wire            op_valid,
  input  wire [3:0]      op_code,
  input  wire [8:0]      op_target,
  input  wire [7:0]      op_file,
  input  wire [2:0]      op_bit,
  input  wire [7:0]      op_literal,
  input  wire [7:0]      work_in,
  output reg  [PC_W-1:0] pc_q,
  output reg  [7:0]      pointer_q,
  output reg  [7:0]      status_q,
  output reg  [7:0]      work_q,
  output reg  [7:0]      counter_q,
  output reg             skip_q,
  output reg             flush_q,
  output reg  [PC_W-1:0] stack_top_q
);
  // ==========================================
  // Operand address resolution.
  wire [7:0]      eff_addr;
  wire [7:0]      rd_data;
  wire [7:0]      mem_data;
  wire [PC_W-1:0] stk [0:DEPTH+1];
  wire            is_page_bank;
  reg             wr_en;
  reg  [7:0]      wr_data;
  reg             skip_d;
  reg  [7:0]      result;
  // R1 R3 indirect resolve
  assign eff_addr = (op_file == `CAS_ADDR_INDIRECT) ? pointer_q : op_file;
  assign mem_data = (eff_addr == `CAS_ADDR_STATUS)  ? status_q  :
                    (eff_addr == `CAS_ADDR_POINTER) ? pointer_q : rd_data;
  assign is_page_bank = (op_code == `CAS_OP_PAGE) || (op_code == `CAS_OP_BANK);

  cas_data_ram #(
    .AW (8)
  ) u_ram (
    .clk     (clk),
    .rd_addr (eff_addr),
    .rd_data (rd_data),
    .wr_en   (wr_en),
    .wr_addr (eff_addr),
    .wr_data (wr_data)
  );

  // ==========================================
  // Data operations.
  always @* begin
    wr_en   = 1'b0;
    wr_data = mem_data;
    skip_d  = 1'b0;
    result  = mem_data;
    if (op_valid && !skip_q) begin
      case (op_code)
        // R6 update and skip
        `CAS_OP_DECSKIP: begin
          result  = mem_data - 8'h01;
          wr_en   = 1'b1;
          wr_data = result;
          skip_d  = (result == 8'h00);
        end
        `CAS_OP_INCSKIP: begin
          result  = mem_data + 8'h01;
          wr_en   = 1'b1;
          wr_data = result;
          skip_d  = (result == 8'h00);
        end
        // R5 bit operations
        `CAS_OP_BITSET: begin
          wr_en   = 1'b1;
          wr_data = mem_data | (8'h01 << op_bit);
        end
        `CAS_OP_BITCLR: begin
          wr_en   = 1'b1;
          wr_data = mem_data & ~(8'h01 << op_bit);
        end
        `CAS_OP_SKIPSET: begin
          skip_d = mem_data[op_bit];
        end
        `CAS_OP_SKIPCLR: begin
          skip_d = ~mem_data[op_bit];
        end
        `CAS_OP_WRITE: begin
          wr_en   = 1'b1;
          wr_data = work_in;
        end
        default: begin
          wr_en = 1'b0;
        end
      endcase
    end
  end

  // ==========================================
  // Return-address stack.
  wire do_push;
  wire do_pop;
  assign do_push = op_valid && !skip_q && (op_code == `CAS_OP_CALL);
  assign do_pop  = op_valid && !skip_q &&
                   ((op_code == `CAS_OP_RETURN) || (op_code == `CAS_OP_RETPAGE) ||
                    (op_code == `CAS_OP_RETADD) || (op_code == `CAS_OP_RETLIT));
  // R10 push incremented PC
  assign stk[0]       = pc_q + {{(PC_W-1){1'b0}}, 1'b1};
  // R17 deepest level kept
  assign stk[DEPTH+1] = stk[DEPTH];
  genvar g;
  generate
    for (g = 1; g <= DEPTH; g = g + 1) begin : g_lvl
      // R7 R16 R18 shifting levels
      cas_stack_level #(
        .W (PC_W)
      ) u_lvl (
        .clk       (clk),
        .reset_n   (reset_n),
        .push      (do_push),
        .pop       (do_pop),
        .shallower (stk[g-1]),
        .deeper    (stk[g+1]),
        .level_q   (stk[g])
      );
    end
  endgenerate

  // ==========================================
  // Program counter, pointer, status and work registers.
  wire            take;
  wire            is_jump;
  wire            is_call;
  wire            is_bank;
  wire [1:0]      page_now;
  wire [PC_W-1:0] pc_inc;
  wire [PC_W-1:0] jump_pc;
  wire [PC_W-1:0] call_pc;
  wire [PC_W-1:0] pop_pc;
  reg  [PC_W-1:0] pc_d;
  reg  [7:0]      pointer_d;
  reg  [7:0]      status_d;
  reg  [7:0]      work_d;
  reg  [7:0]      counter_d;
  reg             skip_next_d;
  reg             flush_d;
  assign take     = op_valid && !skip_q;
  assign is_jump  = take && (op_code == `CAS_OP_JUMP);
  assign is_call  = take && (op_code == `CAS_OP_CALL);
  assign is_bank  = take && (op_code == `CAS_OP_BANK);
  assign page_now = status_q[`CAS_PAGE_MSB:`CAS_PAGE_LSB];
  assign pc_inc   = pc_q + {{(PC_W-1){1'b0}}, 1'b1};
  assign pop_pc   = stk[1];
  // R8 R19 jump
  assign jump_pc  = {page_now, op_target};
  // R11 call target
  assign call_pc  = {page_now, 1'b0, op_target[7:0]};

  // ==========================================
  // Program counter next value.
  always @* begin
    pc_d    = pc_q;
    flush_d = 1'b0;
    if (op_valid) begin
      pc_d = pc_inc;
    end
    if (is_jump) begin
      pc_d    = jump_pc;
      flush_d = 1'b1;
    end
    if (is_call) begin
      pc_d    = call_pc;
      flush_d = 1'b1;
    end
    // R12 R17 pop into PC
    if (do_pop) begin
      pc_d    = pop_pc;
      flush_d = 1'b1;
    end
  end

  // ==========================================
  // Status next value, page bits included.
  always @* begin
    status_d = status_q;
    if (wr_en && (eff_addr == `CAS_ADDR_STATUS)) begin
      status_d = wr_data;
    end
    if (take) begin
      case (op_code)
        // R9 page select
        `CAS_OP_PAGE: begin
          status_d[`CAS_PAGE_MSB:`CAS_PAGE_LSB] = op_target[1:0];
        end
        // R13 R21 paged return
        `CAS_OP_RETPAGE: begin
          status_d[`CAS_PAGE_MSB:`CAS_PAGE_LSB] = pop_pc[PC_W-1:PC_W-2];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================
  // Data pointer next value.
  always @* begin
    pointer_d = pointer_q;
    if (wr_en && (eff_addr == `CAS_ADDR_POINTER)) begin
      pointer_d = wr_data;
    end
    // R2 R4 bank bits only
    if (is_bank) begin
      pointer_d[`CAS_BANK_MSB:`CAS_BANK_LSB] = op_literal[`CAS_BANK_MSB:`CAS_BANK_LSB];
    end
  end

  // ==========================================
  // Working register and realtime counter next values.
  always @* begin
    work_d    = work_q;
    counter_d = counter_q;
    if (take) begin
      case (op_code)
        // R12 plain return
        `CAS_OP_RETURN: begin
          work_d = work_q;
        end
        // R14 add to counter
        `CAS_OP_RETADD: begin
          counter_d = counter_q + work_in;
        end
        // R15 literal return
        `CAS_OP_RETLIT: begin
          work_d = op_literal;
        end
        default: begin
          work_d = work_q;
        end
      endcase
    end
  end

  // ==========================================
  // Skip state next value.
  always @* begin
    skip_next_d = skip_q;
    if (op_valid) begin
      if (skip_q) begin
        // R20 skip chain
        skip_next_d = is_page_bank;
      end else begin
        // R6 skip on zero
        skip_next_d = skip_d;
      end
    end
  end

  // ==========================================
  // Registers.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_q <= `CAS_PC_RST;
    end else begin
      pc_q <= pc_d;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pointer_q <= `CAS_POINTER_RST;
    end else begin
      pointer_q <= pointer_d;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= `CAS_STATUS_RST;
    end else begin
      status_q <= status_d;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      work_q <= `CAS_WORK_RST;
    end else begin
      work_q <= work_d;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      counter_q <= `CAS_COUNT_RST;
    end else begin
      counter_q <= counter_d;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      skip_q <= 1'b0;
    end else begin
      skip_q <= skip_next_d;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flush_q <= 1'b0;
    end else begin
      flush_q <= flush_d;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stack_top_q <= {PC_W{1'b0}};
    end else begin
      stack_top_q <= pop_pc;
    end
  end
endmodule

/* core/cas_map.vh */
`ifndef CAS_MAP_VH
`define CAS_MAP_VH
// ==========================================
// Operation codes presented on op_code.
`define CAS_OP_NONE      4'h0
`define CAS_OP_JUMP      4'h1
`define CAS_OP_CALL      4'h2
`define CAS_OP_RETURN    4'h3
`define CAS_OP_RETPAGE   4'h4
`define CAS_OP_RETADD    4'h5
`define CAS_OP_RETLIT    4'h6
`define CAS_OP_PAGE      4'h7
`define CAS_OP_BANK      4'h8
`define CAS_OP_DECSKIP   4'h9
`define CAS_OP_INCSKIP   4'hA
`define CAS_OP_BITSET    4'hB
`define CAS_OP_BITCLR    4'hC
`define CAS_OP_SKIPSET   4'hD
`define CAS_OP_SKIPCLR   4'hE
`define CAS_OP_WRITE     4'hF
// ==========================================
// Register addresses, field positions and reset values.
`define CAS_ADDR_INDIRECT 8'h00
`define CAS_ADDR_STATUS   8'h03
`define CAS_ADDR_POINTER  8'h04
`define CAS_PAGE_LSB      5
`define CAS_PAGE_MSB      6
`define CAS_BANK_LSB      5
`define CAS_BANK_MSB      7
`define CAS_POINTER_RST   8'h80
`define CAS_STATUS_RST    8'h00
`define CAS_PC_RST        11'h7FF
`define CAS_WORK_RST      8'h00
`define CAS_COUNT_RST     8'h00
`endif

/* core/cas_stack_level.v */
// ==========================================
// One return-address stack level.
module cas_stack_level #(
  parameter W = 11
) (
  input  wire         clk,
  input  wire         reset_n,
  input  wire         push,
  input  wire         pop,
  input  wire [W-1:0] shallower,
  input  wire [W-1:0] deeper,
  output reg  [W-1:0] level_q
);
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      level_q <= {W{1'b0}};
    end else if (push) begin
      level_q <= shallower;
    end else if (pop) begin
      level_q <= deeper;
    end
  end
endmodule

/* core/cas_data_ram.v */
// ==========================================
// Data space of 256 bytes, one read and one write port.
module cas_data_ram #(
  parameter AW = 8
) (
  input  wire          clk,
  input  wire [AW-1:0] rd_addr,
  output wire [7:0]    rd_data,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [7:0]    wr_data
);
  reg [7:0] mem [0:(1<<AW)-1];
  assign rd_data = mem[rd_addr];
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
endmodule

/* dv/cas_core_monitor.sv */
`include "cas_map.vh"
// ==========================================
// Port checker.
module cas_core_monitor #(
  parameter PC_W  = 11,
  parameter DEPTH = 8
) (
  input wire            clk,
  input wire            reset_n,
  input wire            op_valid,
  input wire [3:0]      op_code,
  input wire [8:0]      op_target,
  input wire [7:0]      op_file,
  input wire [2:0]      op_bit,
  input wire [7:0]      op_literal,
  input wire [7:0]      work_in,
  input wire [PC_W-1:0] pc_q,
  input wire [7:0]      pointer_q,
  input wire [7:0]      status_q,
  input wire [7:0]      work_q,
  input wire [7:0]      counter_q,
  input wire            skip_q,
  input wire            flush_q,
  input wire [PC_W-1:0] stack_top_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire       go = op_valid && !skip_q;
  wire [3:0] oc = op_code;
  a_jump_pc: assert property (go && oc == `CAS_OP_JUMP |=>
    pc_q == {$past(status_q[6:5]), $past(op_target)}) else $error("jump pc wrong");
  a_call_pc: assert property (go && oc == `CAS_OP_CALL |=>
    pc_q == {$past(status_q[6:5]), 1'b0, $past(op_target[7:0])}) else $error("call pc wrong");
  a_call_push: assert property (go && oc == `CAS_OP_CALL |=> ##1
    stack_top_q == $past(pc_q, 2) + 1'b1) else $error("call push wrong");
  a_pop_pc: assert property (go && oc >= `CAS_OP_RETURN && oc <= `CAS_OP_RETLIT |=>
    pc_q == stack_top_q) else $error("pop pc wrong");
  a_return_work: assert property (go && oc == `CAS_OP_RETURN |=> $stable(work_q))
    else $error("plain return changed work");
  a_paged_page: assert property (go && oc == `CAS_OP_RETPAGE |=>
    status_q[6:5] == pc_q[PC_W-1:PC_W-2]) else $error("paged return page wrong");
  a_retadd_count: assert property (go && oc == `CAS_OP_RETADD |=>
    counter_q == $past(counter_q) + $past(work_in)) else $error("counter add wrong");
  a_retlit_work: assert property (go && oc == `CAS_OP_RETLIT |=>
    work_q == $past(op_literal)) else $error("literal return wrong");
  a_page_bits: assert property (go && oc == `CAS_OP_PAGE |=>
    status_q[6:5] == $past(op_target[1:0])) else $error("page bits wrong");
  a_bank_bits: assert property (go && oc == `CAS_OP_BANK |=>
    pointer_q == {$past(op_literal[7:5]), $past(pointer_q[4:0])}) else $error("bank wrong");
  c_call2: cover property (go && oc == `CAS_OP_CALL ##1 go && oc == `CAS_OP_CALL);
  c_skip: cover property ($rose(skip_q));
  c_retlit: cover property (go && oc == `CAS_OP_RETLIT);
endmodule
bind cas_core cas_core_monitor #(.PC_W(PC_W), .DEPTH(DEPTH)) cas_core_monitor_i (.clk, .reset_n,
  .op_valid, .op_code, .op_target, .op_file, .op_bit, .op_literal, .work_in, .pc_q,
  .pointer_q, .status_q, .work_q, .counter_q, .skip_q, .flush_q, .stack_top_q);

/* dv/tb.sv */
`include "cas_map.vh"
// ==========================================
// Testbench.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, reset_n = 0, op_valid = 0, skip_q, flush_q;
  logic [3:0]  op_code = 0;
  logic [8:0]  op_target = 0;
  logic [7:0]  op_file = 0, op_literal = 0, work_in = 0;
  logic [2:0]  op_bit = 0;
  logic [10:0] pc_q, stack_top_q;
  logic [7:0]  pointer_q, status_q, work_q, counter_q;
  int          miscompares = 0, checks_done = 0;
  cas_core cas_core_i (.clk, .reset_n, .op_valid, .op_code, .op_target, .op_file, .op_bit,
    .op_literal, .work_in, .pc_q, .pointer_q, .status_q, .work_q, .counter_q, .skip_q,
    .flush_q, .stack_top_q);
  initial forever #5 clk = ~clk;
  task automatic chk(input string n, input logic [10:0] s, input logic [10:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic op(input logic [3:0] c, input logic [8:0] t, input logic [7:0] f, w);
    @(posedge clk);
    op_valid <= 1;
    op_code <= c;
    op_target <= t;
    op_bit <= t[2:0];
    op_file <= f;
    op_literal <= w;
    work_in <= w;
  endtask
  task automatic idle;
    @(posedge clk);
    op_valid <= 0;
    #1;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic t_jump;
    op(`CAS_OP_PAGE, 9'h002, 0, 0);
    op(`CAS_OP_JUMP, 9'h1AB, 0, 0);
    idle;
    chk("jump pc", pc_q, 11'h5AB);
    chk("status", status_q, 8'h40);
    chk("jump flush", flush_q, 11'h001);
  endtask
  task automatic t_stack;
    op(`CAS_OP_PAGE, 0, 0, 0);
    for (int i = 0; i < 9; i++) op(`CAS_OP_CALL, 9'h010 + 9'(i), 0, 0);
    idle;
    chk("call pc", pc_q, 11'h018);
    for (int k = 0; k < 9; k++) begin
      op(4'(`CAS_OP_RETURN + k % 4), 0, 0, 8'h21);
      idle;
      chk("pop pc", pc_q, k < 8 ? 11'h018 - 11'(k) : 11'h011);
    end
    chk("counter", counter_q, 8'h42);
    chk("work", work_q, 8'h21);
    op(`CAS_OP_PAGE, 9'h003, 0, 0);
    op(`CAS_OP_RETPAGE, 0, 0, 0);
    idle;
    chk("paged return page", status_q, 8'h00);
  endtask
  task automatic t_bank;
    op(`CAS_OP_WRITE, 0, 8'h04, 8'h0A);
    op(`CAS_OP_BANK, 0, 0, 8'hF0);
    idle;
    chk("bank", pointer_q, 8'hEA);
    chk("bank no flush", flush_q, 11'h000);
  endtask
  task automatic t_skip;
    op(`CAS_OP_WRITE, 0, 8'h04, 8'h70);
    op(`CAS_OP_WRITE, 0, 8'h70, 8'h01);
    op(`CAS_OP_DECSKIP, 0, 8'h00, 0);
    idle;
    chk("dec skip", skip_q, 1);
    op(`CAS_OP_PAGE, 9'h003, 0, 0);
    op(`CAS_OP_BANK, 0, 0, 8'h20);
    op(`CAS_OP_JUMP, 9'h0AA, 0, 0);
    idle;
    chk("skipped page", status_q, 8'h00);
    chk("skipped bank", pointer_q, 8'h70);
    chk("skip done", skip_q, 0);
    op(`CAS_OP_DECSKIP, 0, 8'h00, 0);
    idle;
    chk("no skip", skip_q, 0);
    op(`CAS_OP_INCSKIP, 0, 8'h00, 0);
    idle;
    chk("inc skip", skip_q, 1);
  endtask
  task automatic t_bits;
    op(`CAS_OP_NONE, 0, 0, 0);
    op(`CAS_OP_BITSET, 9'h003, 8'h30, 0);
    op(`CAS_OP_SKIPSET, 9'h003, 8'h30, 0);
    idle;
    chk("bit set", skip_q, 1);
    op(`CAS_OP_NONE, 0, 0, 0);
    op(`CAS_OP_BITCLR, 9'h003, 8'h30, 0);
    op(`CAS_OP_SKIPCLR, 9'h003, 8'h30, 0);
    idle;
    chk("bit clr", skip_q, 1);
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    results;
  end
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1;
    #1;
    chk("reset pc", pc_q, 11'h7FF);
    chk("reset ptr", pointer_q, 8'h80);
    t_jump;
    t_stack;
    t_bank;
    t_skip;
    t_bits;
    results;
  end
endmodule
